// ==== bench/empm_pin_mux_chk.sv ====
// concurrent checks on the external memory pin multiplexer ports
`timescale 1ns/1ns
module empm_pin_mux_chk #(
   parameter int unsigned N = 61
) (
   input  wire logic           CLK_IN,
   input  wire logic           RESET_N_IN,
   input  wire logic           PCI_PIN_SELECT_IN,
   input  wire logic [2:0]     EXT_MEM_PINOUT_SELECT_IN,
   input  wire logic           RMII_PIN_SELECT_IN,
   input  wire logic           CHIP_SELECT3_PIN_ENABLE_IN,
   input  wire logic           CHIP_SELECT4_PIN_ENABLE_IN,
   input  wire logic [N-1:0]   MEM_OE_IN,
   input  wire logic [N-1:0]   PIN_OE_OUT,
   input  wire logic [2*N-1:0] PIN_FUNC_OUT
);
   wire logic [2*N-1:0] f     = PIN_FUNC_OUT;
   wire logic           up    = RESET_N_IN;
   wire logic           pci   = PCI_PIN_SELECT_IN;
   wire logic           rm    = RMII_PIN_SELECT_IN;
   wire logic [2:0]     ext_mem_pinout_select   = EXT_MEM_PINOUT_SELECT_IN;
   wire logic           cfg_c = !pci && ext_mem_pinout_select == 3'h2 && !rm;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   a_fixed_mem_pins:
      assert property ($past(up) |-> f[121:116] == 6'h15 &&
         PIN_OE_OUT[60:58] == $past(MEM_OE_IN[60:58])) else $error("fixed pin left memory");
   a_pci_takes_pins:
      assert property ($past(up) && $past(pci) |-> f[93:78] == 16'haaaa &&
         f[115:100] == 16'haaaa) else $error("pci pins not routed");
   a_async_mode_mem:
      assert property ($past(up) && $past(cfg_c) |-> f[15:14] == 2'h1 &&
         f[77:58] == 20'h55555) else $error("async memory pins missing");
   a_gpio_floor_kept:
      assert property ($past(up) && $past(cfg_c) |-> f[53:34] == 20'h0 && f[99:94] == 6'h0)
         else $error("too few general io pins");
   a_nand_mode_pins:
      assert property ($past(up) && !$past(pci) && $past(ext_mem_pinout_select) == 3'h5 |-> f[33:18] == 16'h5555
         && f[9:6] == 4'h5 && f[15:14] == 2'h1 && f[77:58] == 20'h0) else $error("nand pins wrong");
   a_cs3_own_enable:
      assert property ($past(up) |-> f[17:16] == {1'b0, $past(CHIP_SELECT3_PIN_ENABLE_IN)})
         else $error("chip select 3 pin wrong");
   a_rmii_pins_on:
      assert property ($past(up) && $past(rm) |-> f[53:44] == 10'h3ff && f[95:94] == 2'h3)
         else $error("rmii pins not routed");
   a_clash_to_gpio:
      assert property ($past(up) && $past(rm) && $past(CHIP_SELECT4_PIN_ENABLE_IN) |->
         f[55:54] == 2'h0) else $error("clashing pin not general io");
   a_sb3_follows_aem:
      assert property ($past(up) && !$past(pci) |->
         f[115:100] == ($past(ext_mem_pinout_select) == 3'h2 ? 16'h5555 : 16'h0)) else $error("sub-block 3 wrong");
endmodule : empm_pin_mux_chk
bind empm_pin_mux empm_pin_mux_chk #(.N(N)) chk (.CLK_IN, .RESET_N_IN, .PCI_PIN_SELECT_IN,
   .EXT_MEM_PINOUT_SELECT_IN, .RMII_PIN_SELECT_IN, .CHIP_SELECT3_PIN_ENABLE_IN,
   .CHIP_SELECT4_PIN_ENABLE_IN, .MEM_OE_IN, .PIN_OE_OUT, .PIN_FUNC_OUT);

// ==== bench/empm_pin_mux_test.sv ====
// randomised bench for the external memory pin multiplexer
`timescale 1ns/1ns
module empm_pin_mux_test;
   localparam int N = empm_pkg::PIN_COUNT;
   logic           clk, rst_n, pci, rmii, cs3, cs4, cs5;
   logic [2:0]     ext_mem_pinout_select;
   logic [N-1:0]   drv [4], en [4], rx [4];
   logic [N-1:0]   pins, pout, poe, ext, ext_en;
   logic [2*N-1:0] func;
   logic [31:0]    seed = 32'h00014ae4;
   // rmii corners keep chip select 4/5 low, 0b alone probes the clash
   logic [7:0]     corner [14] = '{8'h00, 8'h08, 8'h27, 8'h20, 8'h2c, 8'h57, 8'h5c, 8'h80,
                                   8'h88, 8'hd7, 8'hdc, 8'h0b, 8'h72, 8'ha5};
   int             fail_count, comparisons;
   empm_pin_mux uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PCI_PIN_SELECT_IN(pci),
      .EXT_MEM_PINOUT_SELECT_IN(ext_mem_pinout_select), .RMII_PIN_SELECT_IN(rmii),
      .CHIP_SELECT3_PIN_ENABLE_IN(cs3), .CHIP_SELECT4_PIN_ENABLE_IN(cs4),
      .CHIP_SELECT5_PIN_ENABLE_IN(cs5), .MEM_OUT_IN(drv[1]), .MEM_OE_IN(en[1]),
      .PCI_OUT_IN(drv[2]), .PCI_OE_IN(en[2]), .RMII_OUT_IN(drv[3]), .RMII_OE_IN(en[3]),
      .GPIO_OUT_IN(drv[0]), .GPIO_OE_IN(en[0]), .PIN_IN(pins), .PIN_OUT_OUT(pout),
      .PIN_OE_OUT(poe), .MEM_IN_OUT(rx[1]), .PCI_IN_OUT(rx[2]), .RMII_IN_OUT(rx[3]),
      .GPIO_IN_OUT(rx[0]), .PIN_FUNC_OUT(func));
   empm_pins_model #(.N(N)) far (.clk_in(clk), .drive_in(pout), .drive_en_in(poe),
      .ext_in(ext), .ext_en_in(ext_en), .pin_out(pins));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // c = {pci, pinout[2:0], rmii, cs3, cs4, cs5}; result 0 gpio 1 mem 2 pci 3 rmii
   function automatic logic [1:0] fn(int i, logic [7:0] c);
      int   g = i + 5;
      logic a = c[6:4] == 3'h2;
      logic n = c[6:4] == 3'h5;
      if (i >= 58) return 2'h1;
      if (i >= 50 || (g >= 44 && g <= 51)) return c[7] ? 2'h2 : {1'b0, a};
      if (g >= 34) return g == 52 ? {c[3], c[3]} : {1'b0, a && g < 52};
      if (g >= 32) return c[3] ? {!c[33-g], !c[33-g]} : {1'b0, c[33-g]};
      if (g >= 27) return {c[3], c[3]};
      if (g >= 22) return 2'h0;
      if (g == 13) return {1'b0, c[2]};
      return {1'b0, a || (n && (g >= 14 || g == 12 || g == 9 || g == 8))};
   endfunction : fn
   task automatic chk(string what, logic [127:0] seen, logic [127:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic print_verdict();
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic apply(logic [7:0] c);
      // no mii select reaches this block, only the reduced-mii one
      // pci here stands for the select set in every block with pci pins
      {pci, ext_mem_pinout_select, rmii, cs3, cs4, cs5} = c;
      for (int k = 0; k < 4; k++) begin
         drv[k] = N'({xs(), xs()});
         en[k] = N'({xs(), xs()});
      end
   endtask : apply
   task automatic expect_out(logic [7:0] c);
      logic [N-1:0]   eo, ee;
      logic [2*N-1:0] ef;
      logic [1:0]     f;
      for (int i = 0; i < N; i++) begin
         f = fn(i, c);
         ef[2*i +: 2] = f;
         eo[i] = drv[f][i];
         ee[i] = en[f][i];
      end
      chk("pin function", func, ef);
      chk("pin drive", pout, eo);
      chk("pin enable", poe, ee);
   endtask : expect_out
   task automatic expect_in(logic [7:0] c);
      logic [N-1:0] e [4];
      for (int k = 0; k < 4; k++) e[k] = '0;
      for (int i = 0; i < N; i++) e[fn(i, c)][i] = ext[i];
      for (int k = 0; k < 4; k++) chk("pin receive", rx[k], e[k]);
   endtask : expect_in
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // whole run is about 400 cycles
   initial begin
      #20000;
      fail_count++;
      print_verdict();
   end
   initial begin
      logic [31:0] r;
      rst_n = 1'b0;
      ext = '0;
      ext_en = '0;
      apply(8'h00);
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int k = 0; k < 314; k++) begin
         r = xs();
         apply(k < 14 ? corner[k] : r[7:0]);
         @(posedge clk);
         #1 expect_out(k < 14 ? corner[k] : r[7:0]);
      end
      // design released on every pin so the outside level is what gets synced
      for (int k = 0; k < 14; k += 3) begin
         r = xs();
         apply(corner[k]);
         for (int j = 0; j < 4; j++) en[j] = '0;
         ext = N'({r, xs()});
         ext_en = '1;
         repeat (10) @(posedge clk);
         #1 expect_in(corner[k]);
      end
      // mid-run reset: every output back to its reset level, then resume
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("reset function", func, '0);
      chk("reset pins", {pout, poe}, '0);
      for (int k = 0; k < 4; k++) chk("reset receive", rx[k], '0);
      rst_n = 1'b1;
      for (int k = 0; k < 14; k++) begin
         apply(corner[k]);
         @(posedge clk);
         #1 expect_out(corner[k]);
      end
      print_verdict();
   end
endmodule : empm_pin_mux_test

// ==== bench/empm_pins_model.sv ====
// far-side pin model: design, external parts or a floating line sets each pin
`timescale 1ns/1ns
module empm_pins_model #(
   parameter int N = 61
) (
   input  wire logic         clk_in,      // system clock
   input  wire logic [N-1:0] drive_in,    // design drive value
   input  wire logic [N-1:0] drive_en_in, // design output enable
   input  wire logic [N-1:0] ext_in,      // level of external parts
   input  wire logic [N-1:0] ext_en_in,   // external parts driving
   output logic      [N-1:0] pin_out      // resolved pin level
);
   // no pulls on these lines: a released pin shows a pattern that flips each cycle
   logic [N-1:0] drift = '0;
   always_ff @(posedge clk_in) begin
      drift <= ~drift;
   end
   assign pin_out = (drive_en_in & drive_in) | (~drive_en_in & ext_en_in & ext_in)
                  | (~drive_en_in & ~ext_en_in & drift);
endmodule : empm_pins_model

// ==== hdl/empm_pin_mux.sv ====
// pin function selector for the external asynchronous memory pin block
`timescale 1ns/1ns
// Notes on behaviour
// R01 - pci off, pinout 010b, rmii off: memory pins on, no pci pins
// R02 - that mode gives 16-bit async memory pins with chip select 2
// R03 - each chip select 3/4/5 enable picks memory select or general io, for 4 and 5 only while rmii is off
// R04 - that mode leaves at least 13 general io pins, more as enables clear
// R05 - pci select 1 hands this block's pci signals to pci
// R06 - pinout 101 gives 8-bit nand pins: data 7..0, address 2..1, controls
// R07 - sub-block 0 follows only pinout, rmii and pci selects
// R08 - sub-block 1 follows pinout, chip select enables and rmii select
// R09 - wait/ready, output and write enable pins are always memory pins
// R10 - sub-block 3 follows only pinout and pci selects
// R11 - software never selects mii and reduced-mii pins together
// R12 - software selects pci in every mux block carrying pci pins
// R13 - with rmii on, software keeps chip select 4 and 5 enables low
// R14 - a pin with no selected peripheral falls back to general io
module empm_pin_mux #(
   parameter int unsigned N = empm_pkg::PIN_COUNT
) (
   input  wire logic           CLK_IN,               // 100 MHz clock
   input  wire logic           RESET_N_IN,           // synchronous reset, active low
   input  wire logic           PCI_PIN_SELECT_IN,    // 1 hands pci pins to pci
   input  wire logic [2:0]     EXT_MEM_PINOUT_SELECT_IN, // memory pinout mode
   input  wire logic           RMII_PIN_SELECT_IN,   // 1 hands rmii pins to the mac
   input  wire logic           CHIP_SELECT3_PIN_ENABLE_IN, // chip select 3 pin enable
   input  wire logic           CHIP_SELECT4_PIN_ENABLE_IN, // chip select 4 pin enable
   input  wire logic           CHIP_SELECT5_PIN_ENABLE_IN, // chip select 5 pin enable
   input  wire logic [N-1:0]   MEM_OUT_IN,           // memory port drive per pin
   input  wire logic [N-1:0]   MEM_OE_IN,            // memory port enable per pin
   input  wire logic [N-1:0]   PCI_OUT_IN,           // pci drive per pin
   input  wire logic [N-1:0]   PCI_OE_IN,            // pci enable per pin
   input  wire logic [N-1:0]   RMII_OUT_IN,          // ethernet mac drive per pin
   input  wire logic [N-1:0]   RMII_OE_IN,           // ethernet mac enable per pin
   input  wire logic [N-1:0]   GPIO_OUT_IN,          // general io drive per pin
   input  wire logic [N-1:0]   GPIO_OE_IN,           // general io enable per pin
   input  wire logic [N-1:0]   PIN_IN,               // level seen on each pin
   output logic      [N-1:0]   PIN_OUT_OUT,          // level driven on each pin
   output logic      [N-1:0]   PIN_OE_OUT,           // high while pin is driven
   output logic      [N-1:0]   MEM_IN_OUT,           // pin level to memory port
   output logic      [N-1:0]   PCI_IN_OUT,           // pin level to pci
   output logic      [N-1:0]   RMII_IN_OUT,          // pin level to ethernet mac
   output logic      [N-1:0]   GPIO_IN_OUT,          // pin level to general io
   output logic      [2*N-1:0] PIN_FUNC_OUT          // current function code per pin
);
   logic [N-1:0] pin_sync;

   empm_sync3 #(
      .WIDTH      (N)
   ) u_sync (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .async_in   (PIN_IN),
      .sync_out   (pin_sync)
   );

   // function of one pin from the configuration fields
   function automatic empm_pkg::empm_func_e pin_func(
      input int unsigned idx,
      input logic        pci,
      input logic [2:0]  pinout,
      input logic        rmii,
      input logic        cs3,
      input logic        cs4,
      input logic        cs5
   );
      int unsigned         gp;
      logic                async_mode;
      logic                mem_mode;
      empm_pkg::empm_func_e f;
      async_mode = (pinout == empm_pkg::PINOUT_ASYNC);
      mem_mode   = async_mode || (pinout == empm_pkg::PINOUT_NAND);
      f          = empm_pkg::EMPM_GPIO;                                  // [R14]
      gp         = idx + empm_pkg::GP_LOW_BASE;
      if (idx >= empm_pkg::SB2_FIRST && idx <= empm_pkg::SB2_LAST) begin
         f = empm_pkg::EMPM_MEM;                                         // [R09]
      end else if (idx >= empm_pkg::SB3_FIRST && idx <= empm_pkg::SB3_LAST) begin
         // sub-block 3: pci wins over the upper address lines
         if (pci) begin
            f = empm_pkg::EMPM_PCI;                                      // [R10] [R05]
         end else if (async_mode) begin
            f = empm_pkg::EMPM_MEM;                                      // [R10]
         end
      end else if (gp >= 44 && gp <= 51) begin
         // sub-block 0 shared with pci
         if (pci) begin
            f = empm_pkg::EMPM_PCI;                                      // [R07] [R05]
         end else if (async_mode) begin
            f = empm_pkg::EMPM_MEM;                                      // [R07] [R01]
         end
      end else if (gp >= 34 && gp <= 43) begin
         // upper data, read/write, address 21: only in the 16-bit mode
         if (async_mode) begin
            f = empm_pkg::EMPM_MEM;                                      // [R07] [R02]
         end
      end else if (gp == 52) begin
         if (rmii) begin
            f = empm_pkg::EMPM_RMII;                                     // [R07]
         end
      end else if (gp == 33 || gp == 32) begin
         // chip select 5 / 4 shares its pin with rmii receive data
         if (!rmii && (gp == 33 ? cs5 : cs4)) begin
            f = empm_pkg::EMPM_MEM;                                      // [R08] [R03]
         end else if (rmii && !(gp == 33 ? cs5 : cs4)) begin
            f = empm_pkg::EMPM_RMII;                                     // [R08]
         end
      end else if (gp >= 27 && gp <= 31) begin
         if (rmii) begin
            f = empm_pkg::EMPM_RMII;                                     // [R08]
         end
      end else if (gp >= 14 && gp <= 21) begin
         if (mem_mode) begin
            f = empm_pkg::EMPM_MEM;                                      // [R08] [R06]
         end
      end else if (gp == 13) begin
         if (cs3) begin
            f = empm_pkg::EMPM_MEM;                                      // [R08] [R03]
         end
      end else if (gp == 12 || gp == 9 || gp == 8) begin
         // chip select 2 and address 1..2 serve both memory modes
         if (mem_mode) begin
            f = empm_pkg::EMPM_MEM;                                      // [R08] [R06] [R02]
         end
      end else if (gp == 11 || gp == 10 || (gp >= 5 && gp <= 7)) begin
         if (async_mode) begin
            f = empm_pkg::EMPM_MEM;                                      // [R08] [R02]
         end
      end
      // 22..26 and 53..54 stay general io, as do 27..31 and 52 while rmii is off, so mode 010b keeps 13 [R04]
      return f;
   endfunction : pin_func

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         empm_pkg::empm_func_e sel;

         always_comb begin
            sel = pin_func(i, PCI_PIN_SELECT_IN, EXT_MEM_PINOUT_SELECT_IN,
                           RMII_PIN_SELECT_IN, CHIP_SELECT3_PIN_ENABLE_IN,
                           CHIP_SELECT4_PIN_ENABLE_IN, CHIP_SELECT5_PIN_ENABLE_IN);
         end

         // drive side: one registered stage so pins change glitch-free
         always_ff @(posedge CLK_IN) begin
            if (!RESET_N_IN) begin
               PIN_OUT_OUT[i] <= empm_pkg::PIN_OUT_RST;
               PIN_OE_OUT[i]  <= empm_pkg::PIN_OE_RST;
            end else begin
               case (sel)
                  empm_pkg::EMPM_MEM: begin
                     PIN_OUT_OUT[i] <= MEM_OUT_IN[i];
                     PIN_OE_OUT[i]  <= MEM_OE_IN[i];
                  end
                  empm_pkg::EMPM_PCI: begin
                     PIN_OUT_OUT[i] <= PCI_OUT_IN[i];
                     PIN_OE_OUT[i]  <= PCI_OE_IN[i];
                  end
                  empm_pkg::EMPM_RMII: begin
                     PIN_OUT_OUT[i] <= RMII_OUT_IN[i];
                     PIN_OE_OUT[i]  <= RMII_OE_IN[i];
                  end
                  default: begin
                     PIN_OUT_OUT[i] <= GPIO_OUT_IN[i];
                     PIN_OE_OUT[i]  <= GPIO_OE_IN[i];
                  end
               endcase
            end
         end

         // receive side: unselected functions see a steady zero
         always_ff @(posedge CLK_IN) begin
            if (!RESET_N_IN) begin
               MEM_IN_OUT[i]  <= empm_pkg::SYNC_RST;
               PCI_IN_OUT[i]  <= empm_pkg::SYNC_RST;
               RMII_IN_OUT[i] <= empm_pkg::SYNC_RST;
               GPIO_IN_OUT[i] <= empm_pkg::SYNC_RST;
            end else begin
               MEM_IN_OUT[i]  <= (sel == empm_pkg::EMPM_MEM)  && pin_sync[i];
               PCI_IN_OUT[i]  <= (sel == empm_pkg::EMPM_PCI)  && pin_sync[i];
               RMII_IN_OUT[i] <= (sel == empm_pkg::EMPM_RMII) && pin_sync[i];
               GPIO_IN_OUT[i] <= (sel == empm_pkg::EMPM_GPIO) && pin_sync[i];
            end
         end

         always_ff @(posedge CLK_IN) begin
            if (!RESET_N_IN) begin
               PIN_FUNC_OUT[2*i+:2] <= 2'(empm_pkg::EMPM_GPIO);
            end else begin
               PIN_FUNC_OUT[2*i+:2] <= 2'(sel);
            end
         end
      end
   endgenerate
endmodule : empm_pin_mux

// ==== hdl/empm_sync3.sv ====
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
module empm_sync3 #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_in,     // system clock
   input  wire logic             reset_n_in, // synchronous reset, active low
   input  wire logic [WIDTH-1:0] async_in,   // signals from the pins
   output logic      [WIDTH-1:0] sync_out    // filtered, clock-aligned copy
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               stage1[b]   <= empm_pkg::SYNC_RST;
               stage2[b]   <= empm_pkg::SYNC_RST;
               stage3[b]   <= empm_pkg::SYNC_RST;
               sync_out[b] <= empm_pkg::SYNC_RST;
            end else begin
               stage1[b] <= async_in[b];
               stage2[b] <= stage1[b];
               stage3[b] <= stage2[b];
               // stage1 is left to the metastability chain only
               if (stage2[b] == stage3[b]) begin
                  sync_out[b] <= stage3[b];
               end
            end
         end
      end
   endgenerate
endmodule : empm_sync3

// ==== inc/empm_pkg.sv ====
// constants and types shared by the external memory pin block multiplexer
package empm_pkg;
   // pin function codes, also reported on the per-pin function status port
   typedef enum logic [1:0] {
      EMPM_GPIO,
      EMPM_MEM,
      EMPM_PCI,
      EMPM_RMII
   } empm_func_e;

   // memory pinout select codes
   localparam logic [2:0] PINOUT_NONE  = 3'h0;
   localparam logic [2:0] PINOUT_ASYNC = 3'h2;
   localparam logic [2:0] PINOUT_NAND  = 3'h5;

   // pin vector layout: index 0..49 is general_io_pin 5..54,
   // 50..57 is general_io_pin 89..96, 58..60 the fixed memory controls
   localparam int unsigned PIN_COUNT     = 61;
   localparam int unsigned GP_LOW_BASE   = 5;
   localparam int unsigned GP_HIGH_BASE  = 89;
   localparam int unsigned SB3_FIRST     = 50;
   localparam int unsigned SB3_LAST      = 57;
   localparam int unsigned SB2_FIRST     = 58;
   localparam int unsigned SB2_LAST      = 60;

   // reset values
   localparam logic        PIN_OUT_RST   = 1'h0;
   localparam logic        PIN_OE_RST    = 1'h0;
   localparam logic        SYNC_RST      = 1'h0;
endpackage : empm_pkg
